// [pkg/astx_pkg.sv]
// Register map, field layout, reset values and states of the serial transmitter
package astx_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_FLAG   = 10'h00c;
  localparam logic [9:0]  IDX_HOLD   = 10'h019;
  localparam logic [9:0]  IDX_ENABLE = 10'h08c;
  localparam logic [9:0]  IDX_CTL    = 10'h098;
  localparam logic [9:0]  IDX_DIV    = 10'h099;
  localparam int          ADDR_W     = 12;

  // Flag and enable register fields
  localparam int          FLAG_TXE_BIT = 4;
  localparam int          IE_TX_BIT    = 4;

  // Transmit control register fields
  localparam int          CTL_CSRC_BIT  = 7;
  localparam int          CTL_NINE_BIT  = 6;
  localparam int          CTL_TRANSMIT_ENABLE_BIT  = 5;
  localparam int          CTL_SYNC_BIT  = 4;
  localparam int          CTL_HS_BIT    = 2;
  localparam int          CTL_EMPTY_BIT = 1;
  localparam int          CTL_NINTH_BIT = 0;

  // Reset values
  localparam logic [7:0]  CTL_RST    = 8'h02;
  localparam logic [7:0]  FLAG_RST   = 8'h00;
  localparam logic [7:0]  ENABLE_RST = 8'h00;
  localparam logic [7:0]  HOLD_RST   = 8'h00;
  localparam logic [7:0]  DIV_RST    = 8'h00;

  // Oversampling per bit and the last count of each
  localparam int          OS_HIGH  = 16;
  localparam int          OS_LOW   = 64;
  localparam logic [5:0]  OSR_HIGH = 6'(OS_HIGH - 1);
  localparam logic [5:0]  OSR_LOW  = 6'(OS_LOW - 1);

  // Last data bit index for eight and nine bit frames
  localparam logic [3:0]  LAST_BIT8 = 4'h7;
  localparam logic [3:0]  LAST_BIT9 = 4'h8;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } astx_state_t;

endpackage : astx_pkg

// [rtl/astx_top.sv]
// Asynchronous serial transmitter with baud generator and AXI4-Lite registers
// Overview of operation
// - NRZ frame: start, eight/nine data, stop
// - Data bits go out LSB first
// - Transmit and receive share format and rate
// - Baud clock x16 when high speed, else x64
// - Dedicated 8-bit baud timer from oscillator
// - No parity; software uses ninth bit
// - Shifting and baud generation halt in sleep
// - Asynchronous mode when sync bit clear
// - Shift register loads when empty or at end of stop bit
// - Empty flag sticky; cleared only by buffer write
// - Interrupt only when enable bit four set
// - Shift-empty status bit, no interrupt
// - Setting transmit enable sets empty flag
// - Start needs loaded buffer and shift clock
// - Buffer write then enable also starts
// - Write into empty shifter passes straight through
// - Clearing enable aborts, resets, floats pin
// - Nine-bit select bit six, ninth bit zero
// - Rate is clock over 64 or 16 times divisor+1
// - Divisor write clears the baud timer
module astx_top
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Device state
  input  wire logic        sleep,
  // Serial pin and interrupt request
  output logic             tx_out,
  output logic             tx_oe,
  output logic             tx_irq
);

  localparam logic [11:0] A_FLAG   = {astx_pkg::IDX_FLAG, 2'b00};
  localparam logic [11:0] A_HOLD   = {astx_pkg::IDX_HOLD, 2'b00};
  localparam logic [11:0] A_ENABLE = {astx_pkg::IDX_ENABLE, 2'b00};
  localparam logic [11:0] A_CTL    = {astx_pkg::IDX_CTL, 2'b00};
  localparam logic [11:0] A_DIV    = {astx_pkg::IDX_DIV, 2'b00};

  // Bus slave state
  logic        aw_got;
  logic        w_got;
  logic [11:0] aw_addr;
  logic [7:0]  w_byte;
  logic        w_low;
  logic        do_write;
  logic        wr_hit;
  logic        ctl_wr;
  logic        hold_wr;
  logic        div_wr;
  logic        ie_wr;
  logic [7:0]  rd_word;
  logic        rd_hit;

  // Software visible state
  logic        ctl_csrc;
  logic        ctl_nine;
  logic        ctl_transmit_enable;
  logic        ctl_sync;
  logic        ctl_hs;
  logic        ctl_ninth;
  logic        ie_tx;
  logic        flag;
  logic [7:0]  div;
  logic [7:0]  hold;
  logic        hb_full;
  logic        transmit_enable_prev;

  // Baud generator and transmitter
  logic [7:0]  brg_cnt;
  logic [5:0]  osr;
  logic [5:0]  osr_lim;
  logic        tick_os;
  logic        bit_tick;
  astx_pkg::astx_state_t state;
  logic [8:0]  transmit_shift_register;
  logic        tsr_nine;
  logic        tsr_full;
  logic [3:0]  bit_idx;
  logic [3:0]  last_idx;
  logic        transmit_enable_act;
  logic        stop_end;
  logic        load;

  assign do_write = aw_got && w_got && !bvalid;
  assign w_low    = wstrb[0];
  assign wr_hit   = (aw_addr == A_FLAG) || (aw_addr == A_HOLD) ||
                    (aw_addr == A_ENABLE) || (aw_addr == A_CTL) ||
                    (aw_addr == A_DIV);
  assign ctl_wr   = do_write && (aw_addr == A_CTL);
  assign hold_wr  = do_write && (aw_addr == A_HOLD);
  assign div_wr   = do_write && (aw_addr == A_DIV);
  assign ie_wr    = do_write && (aw_addr == A_ENABLE);

  // Write address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 12'h000;
      w_byte  <= 8'h00;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= astx_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_got  <= 1'b1;
        w_byte <= w_low ? wdata[7:0] : 8'h00;
        wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_hit ? astx_pkg::RESP_OKAY : astx_pkg::RESP_DECERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Read data mux
  always_comb
  begin
    rd_word = 8'h00;
    rd_hit  = 1'b1;
    case (araddr)
      A_FLAG:   rd_word[astx_pkg::FLAG_TXE_BIT] = flag;
      A_HOLD:   rd_word = hold;
      A_ENABLE: rd_word[astx_pkg::IE_TX_BIT] = ie_tx;
      A_CTL:
      begin
        rd_word[astx_pkg::CTL_CSRC_BIT]  = ctl_csrc;
        rd_word[astx_pkg::CTL_NINE_BIT]  = ctl_nine;
        rd_word[astx_pkg::CTL_TRANSMIT_ENABLE_BIT]  = ctl_transmit_enable;
        rd_word[astx_pkg::CTL_SYNC_BIT]  = ctl_sync;
        rd_word[astx_pkg::CTL_HS_BIT]    = ctl_hs;
        rd_word[astx_pkg::CTL_EMPTY_BIT] = !tsr_full;
        rd_word[astx_pkg::CTL_NINTH_BIT] = ctl_ninth;
      end
      A_DIV:    rd_word = div;
      default:  rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= astx_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_word};
      rresp   <= rd_hit ? astx_pkg::RESP_OKAY : astx_pkg::RESP_DECERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Control, enable and divisor registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_csrc  <= astx_pkg::CTL_RST[astx_pkg::CTL_CSRC_BIT];
      ctl_nine  <= astx_pkg::CTL_RST[astx_pkg::CTL_NINE_BIT];
      ctl_transmit_enable  <= astx_pkg::CTL_RST[astx_pkg::CTL_TRANSMIT_ENABLE_BIT];
      ctl_sync  <= astx_pkg::CTL_RST[astx_pkg::CTL_SYNC_BIT];
      ctl_hs    <= astx_pkg::CTL_RST[astx_pkg::CTL_HS_BIT];
      ctl_ninth <= astx_pkg::CTL_RST[astx_pkg::CTL_NINTH_BIT];
      ie_tx     <= astx_pkg::ENABLE_RST[astx_pkg::IE_TX_BIT];
      div       <= astx_pkg::DIV_RST;
    end
    else
    begin
      if (ctl_wr)
      begin
        ctl_csrc  <= w_byte[astx_pkg::CTL_CSRC_BIT];
        ctl_nine  <= w_byte[astx_pkg::CTL_NINE_BIT];
        ctl_transmit_enable  <= w_byte[astx_pkg::CTL_TRANSMIT_ENABLE_BIT];
        ctl_sync  <= w_byte[astx_pkg::CTL_SYNC_BIT];
        ctl_hs    <= w_byte[astx_pkg::CTL_HS_BIT];
        ctl_ninth <= w_byte[astx_pkg::CTL_NINTH_BIT];
      end
      if (ie_wr)
        ie_tx <= w_byte[astx_pkg::IE_TX_BIT];
      if (div_wr)
        div <= w_byte;
    end
  end

  assign transmit_enable_act = ctl_transmit_enable && !ctl_sync;

  // Holding buffer and its empty flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold      <= astx_pkg::HOLD_RST;
      hb_full   <= 1'b0;
      flag      <= astx_pkg::FLAG_RST[astx_pkg::FLAG_TXE_BIT];
      transmit_enable_prev <= 1'b0;
    end
    else
    begin
      transmit_enable_prev <= ctl_transmit_enable;
      if (hold_wr)
      begin
        hold    <= w_byte;
        hb_full <= 1'b1;
        flag    <= 1'b0;
      end
      else if (load)
      begin
        hb_full <= 1'b0;
        flag    <= 1'b1;
      end
      else if (ctl_transmit_enable && !transmit_enable_prev)
        flag <= 1'b1;
    end
  end

  // Interrupt request gated by its enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_irq <= 1'b0;
    else
      tx_irq <= flag && ie_tx;
  end

  // Baud timer shared by both directions of the port
  assign osr_lim  = ctl_hs ? astx_pkg::OSR_HIGH : astx_pkg::OSR_LOW;
  assign tick_os  = !sleep && !div_wr && (brg_cnt == div);
  assign bit_tick = tick_os && (osr >= osr_lim);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      brg_cnt <= 8'h00;
      osr     <= 6'h00;
    end
    else if (div_wr)
    begin
      brg_cnt <= 8'h00;
      osr     <= 6'h00;
    end
    else if (tick_os)
    begin
      brg_cnt <= 8'h00;
      osr     <= (osr >= osr_lim) ? 6'h00 : 6'(osr + 6'h01);
    end
    else if (!sleep)
      brg_cnt <= 8'(brg_cnt + 8'h01);
  end

  // Shift register load from the holding buffer
  assign stop_end = (state == astx_pkg::ST_STOP) && bit_tick;
  assign load     = transmit_enable_act && !sleep && hb_full && !hold_wr &&
                    (!tsr_full || stop_end);
  assign last_idx = tsr_nine ? astx_pkg::LAST_BIT9 : astx_pkg::LAST_BIT8;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      transmit_shift_register      <= 9'h000;
      tsr_nine <= 1'b0;
      tsr_full <= 1'b0;
    end
    else if (!transmit_enable_act)
      tsr_full <= 1'b0;
    else if (load)
    begin
      transmit_shift_register      <= {ctl_ninth, hold};
      tsr_nine <= ctl_nine;
      tsr_full <= 1'b1;
    end
    else if (stop_end)
      tsr_full <= 1'b0;
  end

  // Frame sequencer and serial pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state   <= astx_pkg::ST_IDLE;
      bit_idx <= 4'h0;
      tx_out  <= 1'b1;
      tx_oe   <= 1'b0;
    end
    else if (!transmit_enable_act)
    begin
      state   <= astx_pkg::ST_IDLE;
      bit_idx <= 4'h0;
      tx_out  <= 1'b1;
      tx_oe   <= 1'b0;
    end
    else if (!sleep)
    begin
      tx_oe <= 1'b1;
      case (state)
        astx_pkg::ST_IDLE:
        begin
          tx_out <= 1'b1;
          if (tsr_full && bit_tick)
          begin
            state  <= astx_pkg::ST_START;
            tx_out <= 1'b0;
          end
        end
        astx_pkg::ST_START:
          if (bit_tick)
          begin
            state   <= astx_pkg::ST_DATA;
            bit_idx <= 4'h0;
            tx_out  <= transmit_shift_register[0];
          end
        astx_pkg::ST_DATA:
          if (bit_tick)
          begin
            if (bit_idx == last_idx)
            begin
              state  <= astx_pkg::ST_STOP;
              tx_out <= 1'b1;
            end
            else
            begin
              bit_idx <= 4'(bit_idx + 4'h1);
              tx_out  <= transmit_shift_register[4'(bit_idx + 4'h1)];
            end
          end
        astx_pkg::ST_STOP:
          if (bit_tick)
          begin
            if (load)
            begin
              state  <= astx_pkg::ST_START;
              tx_out <= 1'b0;
            end
            else
            begin
              state  <= astx_pkg::ST_IDLE;
              tx_out <= 1'b1;
            end
          end
        default:
        begin
          state  <= astx_pkg::ST_IDLE;
          tx_out <= 1'b1;
        end
      endcase
    end
  end

  // Clocks between bit ticks, frozen in sleep
  logic [13:0] gap_cnt;
  logic        gap_ok;
  logic [13:0] gap_exp;

  assign gap_exp = 14'((ctl_hs ? astx_pkg::OS_HIGH : astx_pkg::OS_LOW) *
                       (int'(div) + 1) - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_cnt <= 14'h0000;
      gap_ok  <= 1'b0;
    end
    else if (div_wr || ctl_wr)
    begin
      gap_cnt <= 14'h0000;
      gap_ok  <= 1'b0;
    end
    else if (bit_tick)
    begin
      gap_cnt <= 14'h0000;
      gap_ok  <= 1'b1;
    end
    else if (!sleep)
      gap_cnt <= 14'(gap_cnt + 14'h0001);
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_start_bit_low: assert property (
    (state == astx_pkg::ST_START) |-> (!tx_out && tx_oe))
    else $error("start bit not low");
  a_stop_bit_high: assert property (
    (state == astx_pkg::ST_STOP) |-> tx_out)
    else $error("stop bit not high");
  a_lsb_goes_first: assert property (
    $rose(state == astx_pkg::ST_DATA) |-> (tx_out == transmit_shift_register[0]))
    else $error("first data bit is not bit zero");
  a_flag_stays_set: assert property (
    (flag && !hold_wr) |=> flag)
    else $error("empty flag cleared without buffer write");
  a_irq_needs_enable: assert property (
    (!ie_tx && !$past(ie_tx)) |-> !tx_irq)
    else $error("interrupt raised while disabled");
  a_load_sets_flag: assert property (
    load |=> (flag && !hb_full && tsr_full))
    else $error("buffer transfer did not complete in one cycle");
  a_abort_floats_pin: assert property (
    !transmit_enable_act |=> (!tx_oe && !tsr_full && state == astx_pkg::ST_IDLE))
    else $error("disable did not reset transmitter");
  a_start_on_tick: assert property (
    $rose(state == astx_pkg::ST_START) |-> $past(bit_tick))
    else $error("frame started without shift clock");
  a_div_clears_timer: assert property (
    div_wr |=> (brg_cnt == 8'h00 && osr == 6'h00))
    else $error("divisor write left timer running");
  a_sleep_freezes: assert property (
    (sleep && transmit_enable_act && !ctl_wr) |=> $stable(state) && $stable(osr))
    else $error("activity during sleep");
  a_bit_tick_rate: assert property (
    (bit_tick && gap_ok) |-> (gap_cnt == gap_exp))
    else $error("bit tick spacing differs from oversampling rate");

  c_back_to_back: cover property (stop_end && load);
  c_nine_bit_frame: cover property (
    (state == astx_pkg::ST_DATA) && (bit_idx == astx_pkg::LAST_BIT9));
  c_abort_mid_frame: cover property (
    (state == astx_pkg::ST_DATA) ##1 !transmit_enable_act);
  c_divisor_write: cover property (div_wr && brg_cnt != 8'h00);

endmodule : astx_top

// [testbench/astx_link_rx.sv]
// Remote serial receiver model sampling the transmit line at mid bit
module astx_link_rx
(
  // Clock
  input  wire logic        aclk,
  // Serial pin
  input  wire logic        tx_out,
  input  wire logic        tx_oe,
  // Frame format
  input  wire logic [15:0] bit_cyc,
  input  wire logic        nine,
  // Received character
  output logic             got,
  output logic [8:0]       data,
  output logic             ferr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic line;

  // Released pin is pulled up
  assign line = tx_oe ? tx_out : 1'b1;

  initial
  begin
    got = 1'b0;
    data = 9'h000;
    ferr = 1'b0;
    forever
    begin
      @(posedge aclk);
      got <= 1'b0;
      if (line === 1'b0)
      begin
        data <= 9'h000;
        repeat (bit_cyc / 2) @(posedge aclk);
        for (int i = 0; i < (nine ? 9 : 8); i++)
        begin
          repeat (bit_cyc) @(posedge aclk);
          data[i] <= line;
        end
        repeat (bit_cyc) @(posedge aclk);
        ferr <= (line !== 1'b1);
        got <= 1'b1;
      end
    end
  end
endmodule : astx_link_rx

// [testbench/astx_top_test.sv]
// Self-checking bench for the serial transmitter with a behavioural model
module astx_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, sleep;
  logic        tx_out, tx_oe, tx_irq, rx_got, rx_ferr, drop;
  logic [11:0] awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] bit_cyc;
  logic [8:0]  rx_data;
  logic [7:0]  m_ctl, d;
  logic [9:0]  exp_q[$];
  int          n_mismatch, n_tests, seed, m_div;

  astx_top i_astx_top
  (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sleep, .tx_out, .tx_oe, .tx_irq
  );

  astx_link_rx i_astx_link_rx
  (
    .aclk, .tx_out, .tx_oe, .bit_cyc, .nine(m_ctl[6]), .got(rx_got),
    .data(rx_data), .ferr(rx_ferr)
  );

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t reg got=%h exp=%h", $time, g, e);
    end
  endtask : chk_reg

  task automatic chk_char(input logic [9:0] g, input logic [9:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t char got=%h exp=%h", $time, g, e);
    end
  endtask : chk_char

  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr

  task automatic rd_chk(input logic [9:0] i, input logic [7:0] e);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    rv = rdata;
    resp = rresp;
    chk_reg(rv, {24'h0, e});
  endtask : rd_chk

  task automatic wctl(input logic [7:0] v);
    wr(astx_pkg::IDX_CTL, v);
    m_ctl = v;
    bit_cyc = 16'((v[2] ? 16 : 64) * (m_div + 1));
  endtask : wctl

  task automatic send(input logic [7:0] v);
    wr(astx_pkg::IDX_HOLD, v);
    exp_q.push_back({1'b0, m_ctl[6] & m_ctl[0], v});
  endtask : send

  task automatic wait_done;
    while (exp_q.size() != 0)
      @(posedge aclk);
    repeat (bit_cyc) @(posedge aclk);
  endtask : wait_done

  task automatic results;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  always @(posedge aclk)
    if (rx_got && !drop)
      chk_char({rx_ferr, rx_data}, exp_q.pop_front());

  // Watchdog sized for about 23 frames at the slowest rate used
  initial
  begin
    #300000;
    n_mismatch++;
    results();
  end

  initial
  begin
    seed = 20;
    m_ctl = 8'h00;
    bit_cyc = 16'd64;
    drop = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, sleep} <= 6'h00;
    {awaddr, araddr, wdata} <= 56'h0;
    {awprot, arprot, wstrb} <= 10'h00f;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(astx_pkg::IDX_CTL, 8'h02);
    rd_chk(astx_pkg::IDX_FLAG, 8'h00);
    rd_chk(astx_pkg::IDX_ENABLE, 8'h00);
    rd_chk(astx_pkg::IDX_DIV, 8'h00);
    rd_chk(astx_pkg::IDX_HOLD, 8'h00);
    rd_chk(10'h001, 8'h00);
    chk_reg(32'(resp), 32'(astx_pkg::RESP_DECERR));
    wr(10'h001, 8'hff);
    chk_reg(32'(resp), 32'(astx_pkg::RESP_DECERR));
    $display("test reset done");
    wr(astx_pkg::IDX_ENABLE, 8'h10);
    wctl(8'h24);
    rd_chk(astx_pkg::IDX_FLAG, 8'h10);
    wr(astx_pkg::IDX_FLAG, 8'h00);
    rd_chk(astx_pkg::IDX_FLAG, 8'h10);
    chk_reg(32'(tx_irq), 32'h1);
    wr(astx_pkg::IDX_ENABLE, 8'h00);
    repeat (2) @(posedge aclk);
    chk_reg(32'(tx_irq), 32'h0);
    chk_reg(32'({tx_oe, tx_out}), 32'h3);
    $display("test enable done");
    for (int m = 0; m < 2; m++)
    begin
      m_div = $random(seed) & 1;
      wr(astx_pkg::IDX_DIV, 8'(m_div));
      wctl(m ? 8'h24 : 8'h20);
      d = 8'($random(seed));
      send(d);
      rd_chk(astx_pkg::IDX_FLAG, 8'h10);
      send(~d);
      rd_chk(astx_pkg::IDX_FLAG, 8'h00);
      rd_chk(astx_pkg::IDX_CTL, m_ctl);
      wait_done();
      rd_chk(astx_pkg::IDX_CTL, m_ctl | 8'h02);
      rd_chk(astx_pkg::IDX_FLAG, 8'h10);
    end
    $display("test rates done");
    // Ninth bit goes in before each data byte
    wctl(8'h65);
    send(8'($random(seed)));
    wctl(8'h64);
    send(8'($random(seed)));
    wait_done();
    $display("test nine-bit done");
    wctl(8'h24);
    sleep <= 1'b1;
    send(8'($random(seed)));
    repeat (200) @(posedge aclk);
    rd_chk(astx_pkg::IDX_FLAG, 8'h00);
    chk_reg(32'(tx_out), 32'h1);
    sleep <= 1'b0;
    wait_done();
    $display("test sleep done");
    send(8'($random(seed)));
    drop = 1'b1;
    repeat (40) @(posedge aclk);
    wctl(8'h04);
    @(posedge aclk);
    chk_reg(32'(tx_oe), 32'h0);
    rd_chk(astx_pkg::IDX_CTL, 8'h06);
    repeat (400) @(posedge aclk);
    exp_q.delete();
    drop = 1'b0;
    send(8'($random(seed)));
    wctl(8'h24);
    wait_done();
    $display("test abort done");
    results();
  end
endmodule : astx_top_test
